// ==== design/msc_top.sv ====
/*
  Maintenance step control: gates subroutine returns and shift steps with
  the maintenance switches, holds the processor at each step and lets the
  key-cycle pulses supply the missing returns; also steers the split-cycle
  memory request and the repeat delay trigger.
  Assumes the key chain, repeat delay and memory bus live outside; all
  inputs are synchronous levels or one-cycle pulses on mclk.
*/
// Summary of operation
// - Readin hold keeps readin mode flag set
// - Repeat skip lets first key pulse start delay
// - Arith hold blocks carry return; mid pulse returns
// - Arith hold halts after every arithmetic subroutine
// - Shift hold blocks step pulses; mid pulse steps
// - Shift hold stops before and after each step
// - Memory halt lets address pulse set split flop
// - Split flop with fetch-pause gives read only
// - Override switch disables split flop set gate
// - Memory halt lights lamp and waiting flag
// - Auto repeat needs last key pulse for delay
// - Resume after step stop only supplies return
// - Resume key held restarts key cycle at any stop
// - All three holds combine; resume clears each
`timescale 1ns/100ps
module msc_top
  import msc_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire msc_switch_t sw,
  input wire msc_key_t key,
  input wire msc_proc_t proc,
  input wire logic mem_halt_key,
  input wire logic addr_match_halt_switch,
  input wire logic auto_repeat_switch,
  input wire logic mem_resume_key,
  output logic readin_mode_flag,
  output logic arith_return_pulse,
  output logic shift_advance_pulse,
  output logic repeat_delay_start,
  output logic key_cycle_start,
  output logic mem_read_only_req,
  output logic mem_full_cycle_req,
  output logic split_sync_flag,
  output logic proc_halted,
  output logic mem_halted_lamp,
  output logic arith_wait_lamp,
  output logic shift_wait_lamp,
  output logic [1:0] subroutine_flag
);

  logic arith_wait_r;
  logic shift_wait_r;
  logic mem_wait_r;
  logic mem_halt_on;
  logic step_stop;
  logic arith_ret_nxt;
  logic shift_adv_nxt;

  assign mem_halt_on = mem_halt_key | addr_match_halt_switch;
  assign step_stop = arith_wait_r | shift_wait_r;

  // with the hold switches low the processor events pass straight through
  assign arith_ret_nxt = sw.arith_return_hold_switch ?
                         (arith_wait_r & key.key_pulse_mid) :
                         proc.arith_carry_done;
  assign shift_adv_nxt = sw.shift_step_hold_switch ?
                         (shift_wait_r & key.key_pulse_mid) :
                         (proc.shift_step_pulse_a | proc.shift_step_pulse_b);

  // Readin mode; the hold switch pins the flag so no fetch clears it
  always_ff @(posedge mclk)
  begin
    if (srst)
      readin_mode_flag <= READIN_RST;
    else if (proc.readin_set || sw.readin_hold_switch)
      readin_mode_flag <= 1'b1;
    else if (proc.readin_clear)
      readin_mode_flag <= 1'b0;
  end

  // Arithmetic stop: waits for the key-generated return
  always_ff @(posedge mclk)
  begin
    if (srst)
      arith_wait_r <= ARITH_WAIT_RST;
    else if (sw.arith_return_hold_switch && proc.arith_carry_done)
      arith_wait_r <= 1'b1;
    else if (key.key_pulse_mid)
      arith_wait_r <= 1'b0;
  end

  // Shift stop: set on entry and after each step, so every step needs a key
  always_ff @(posedge mclk)
  begin
    if (srst)
      shift_wait_r <= SHIFT_WAIT_RST;
    else if (sw.shift_step_hold_switch &&
             (proc.shift_enter || proc.shift_step_pulse_a || proc.shift_step_pulse_b))
      shift_wait_r <= 1'b1;
    else if (key.key_pulse_mid)
      shift_wait_r <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      arith_return_pulse <= 1'b0;
      shift_advance_pulse <= 1'b0;
    end
    else
    begin
      arith_return_pulse <= arith_ret_nxt;
      shift_advance_pulse <= shift_adv_nxt;
    end
  end

  // Split-cycle sync flop; set gate dropped by the override switch
  always_ff @(posedge mclk)
  begin
    if (srst)
      split_sync_flag <= SPLIT_SYNC_RST;
    else if (mem_halt_on && proc.address_time_pulse && !sw.split_sync_inhibit_switch)
      split_sync_flag <= 1'b1;
    else if (!mem_halt_on)
      split_sync_flag <= 1'b0;
  end

  // Read-only request avoids holding memory through a stop
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      mem_read_only_req <= 1'b0;
      mem_full_cycle_req <= 1'b0;
    end
    else
    begin
      mem_read_only_req <= proc.fetch_pause_req & split_sync_flag;
      mem_full_cycle_req <= proc.fetch_pause_req & ~split_sync_flag;
    end
  end

  // Memory stop after a call while halting is armed
  always_ff @(posedge mclk)
  begin
    if (srst)
      mem_wait_r <= MEM_WAIT_RST;
    else if (mem_halt_on && (proc.mem_call_done || proc.mem_read_done))
      mem_wait_r <= 1'b1;
    else if (key.key_pulse_mid && !step_stop)
      mem_wait_r <= 1'b0;
  end

  // Repeat delay trigger and automatic key-cycle restart
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      repeat_delay_start <= 1'b0;
      key_cycle_start <= 1'b0;
    end
    else
    begin
      if (sw.repeat_skip_switch)
        repeat_delay_start <= key.key_pulse_first;
      else
        repeat_delay_start <= auto_repeat_switch & key.key_pulse_last;
      // Only a halted processor has anything for the resume key to restart
      key_cycle_start <= mem_resume_key & (step_stop | mem_wait_r) &
                         ~key.key_pulse_first;
    end
  end

  // Indicators; flag code 1 arith, 2 shift, 3 memory
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      proc_halted <= 1'b0;
      mem_halted_lamp <= 1'b0;
      arith_wait_lamp <= 1'b0;
      shift_wait_lamp <= 1'b0;
      subroutine_flag <= 2'h0;
    end
    else
    begin
      proc_halted <= step_stop | mem_wait_r;
      mem_halted_lamp <= mem_wait_r;
      arith_wait_lamp <= arith_wait_r;
      shift_wait_lamp <= shift_wait_r;
      if (arith_wait_r)
        subroutine_flag <= 2'h1;
      else if (shift_wait_r)
        subroutine_flag <= 2'h2;
      else if (mem_wait_r)
        subroutine_flag <= 2'h3;
      else
        subroutine_flag <= 2'h0;
    end
  end

endmodule

// ==== common/msc_pkg.sv ====
/*
  Package for the maintenance step control block: carrier structs for the
  maintenance switch set, key-cycle pulses and processor-side events.
  Assumes all inputs are synchronous to mclk and pulses are one cycle wide.
*/
package msc_pkg;

  // Reset values of the held flags
  localparam logic SPLIT_SYNC_RST = 1'b0;
  localparam logic ARITH_WAIT_RST = 1'b0;
  localparam logic SHIFT_WAIT_RST = 1'b0;
  localparam logic MEM_WAIT_RST = 1'b0;
  localparam logic READIN_RST = 1'b0;

  // Toggle switches on the wiring side; all off when low
  typedef struct packed {
    logic readin_hold_switch;
    logic repeat_skip_switch;
    logic arith_return_hold_switch;
    logic shift_step_hold_switch;
    logic split_sync_inhibit_switch;
  } msc_switch_t;

  // Console key-cycle pulse chain
  typedef struct packed {
    logic key_pulse_first;
    logic key_pulse_mid;
    logic key_pulse_last;
  } msc_key_t;

  // Events offered by the processor's own control timing
  typedef struct packed {
    logic readin_set;
    logic readin_clear;
    logic arith_carry_done;
    logic shift_enter;
    logic shift_step_pulse_a;
    logic shift_step_pulse_b;
    logic address_time_pulse;
    logic fetch_pause_req;
    logic mem_call_done;
    logic mem_read_done;
  } msc_proc_t;

endpackage

// ==== testbench/msc_assertions.sv ====
/*
  Checker for msc_top: switch, pulse and output relations.
  Assumes all inputs are synchronous to mclk; bound at the foot.
*/
`timescale 1ns/100ps
module msc_assertions
  import msc_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire msc_switch_t sw,
  input wire msc_key_t key,
  input wire msc_proc_t proc,
  input wire logic mem_halt_key,
  input wire logic auto_repeat_switch,
  input wire logic readin_mode_flag,
  input wire logic arith_return_pulse,
  input wire logic shift_advance_pulse,
  input wire logic repeat_delay_start,
  input wire logic mem_read_only_req,
  input wire logic split_sync_flag,
  input wire logic proc_halted,
  input wire logic mem_halted_lamp,
  input wire logic [1:0] subroutine_flag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  readin_hold_a: assert property (sw.readin_hold_switch |=> readin_mode_flag)
    else $error("readin flag dropped");
  arith_block_a: assert property (sw.arith_return_hold_switch && proc.arith_carry_done
    && !key.key_pulse_mid |=> !arith_return_pulse) else $error("carry gave return");
  arith_halt_a: assert property (sw.arith_return_hold_switch && proc.arith_carry_done
    ##1 !key.key_pulse_mid |=> proc_halted) else $error("no arith halt");
  shift_block_a: assert property (sw.shift_step_hold_switch && proc.shift_step_pulse_a
    && !key.key_pulse_mid |=> !shift_advance_pulse) else $error("step advanced");
  skip_repeat_a: assert property (sw.repeat_skip_switch && key.key_pulse_first
    |=> repeat_delay_start) else $error("no skip delay");
  auto_repeat_a: assert property (auto_repeat_switch && key.key_pulse_last
    |=> repeat_delay_start) else $error("no repeat delay");
  split_set_a: assert property (mem_halt_key && proc.address_time_pulse
    && !sw.split_sync_inhibit_switch |=> split_sync_flag) else $error("split not set");
  split_gate_a: assert property (sw.split_sync_inhibit_switch && !split_sync_flag
    |=> !split_sync_flag) else $error("split set while inhibited");
  read_only_a: assert property (split_sync_flag && proc.fetch_pause_req
    |=> mem_read_only_req) else $error("no read only request");
  normal_ret_a: assert property (!sw.arith_return_hold_switch && proc.arith_carry_done
    |=> arith_return_pulse) else $error("no normal return");
  mem_lamp_a: assert property (mem_halt_key && proc.mem_call_done ##1 !key.key_pulse_mid
    |=> mem_halted_lamp && subroutine_flag != 2'h0) else $error("no memory stop lamp");
  cover property (proc_halted);
  cover property (split_sync_flag);
  cover property (repeat_delay_start);
endmodule
bind msc_top msc_assertions msc_assertions_inst (.*);

// ==== testbench/msc_console.sv ====
/*
  Console key model: a kick runs first, mid and last key pulses.
  Assumes kick is a one-cycle pulse from the bench.
*/
`timescale 1ns/100ps
module msc_console
  import msc_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic kick,
  output wire msc_key_t key
);
  logic [2:0] chain_r;
  // A slow console is modelled by the bench kicking later
  always_ff @(posedge mclk)
  begin
    chain_r <= srst ? 3'h0 : {chain_r[1:0], kick};
  end
  assign key = '{chain_r[0], chain_r[1], chain_r[2]};
endmodule

// ==== testbench/msc_top_tb_top.sv ====
/*
  Bench for msc_top: one task per scenario, inputs on the falling edge.
  Assumes msc_console supplies the key pulses.
*/
`timescale 1ns/100ps
module msc_top_tb_top import msc_pkg::*;;
  logic mclk = 0, srst = 1, kick = 0, mhk = 0, arp = 0, mrk = 0;
  msc_switch_t sw = '0;
  msc_proc_t proc = '0;
  msc_key_t key;
  logic rflag, halted, split, ksc, rds, mro, mfc, mlamp;
  logic [1:0] sflag;
  int num_errors = 0, cmp_count = 0;
  always #10 mclk = ~mclk;
  msc_console msc_console_inst (.mclk, .srst, .kick, .key);
  msc_top msc_top_inst (.mclk, .srst, .sw, .key, .proc, .mem_halt_key(mhk),
    .addr_match_halt_switch(1'b0), .auto_repeat_switch(arp), .mem_resume_key(mrk),
    .readin_mode_flag(rflag), .arith_return_pulse(), .shift_advance_pulse(),
    .repeat_delay_start(rds), .key_cycle_start(ksc), .mem_read_only_req(mro),
    .mem_full_cycle_req(mfc), .split_sync_flag(split), .proc_halted(halted),
    .mem_halted_lamp(mlamp), .arith_wait_lamp(), .shift_wait_lamp(),
    .subroutine_flag(sflag));
  task tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task chk(input logic a, input logic e);
    cmp_count++;
    if (a !== e)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, a, e);
    end
  endtask
  task kick_keys;
    kick = 1;
    tick(1);
    kick = 0;
    tick(5);
  endtask
  task t_readin;
    sw.readin_hold_switch = 1;
    proc.readin_clear = 1;
    tick(1);
    proc = '0;
    tick(2);
    chk(rflag, 1);
    sw = '0;
  endtask
  task t_arith;
    sw.arith_return_hold_switch = 1;
    mrk = 1;
    proc.arith_carry_done = 1;
    tick(1);
    proc = '0;
    tick(3);
    chk(halted, 1);
    chk(ksc, 1);
    kick_keys;
    chk(halted, 0);
    sw = '0;
    proc.arith_carry_done = 1;
    tick(1);
    proc = '0;
    tick(3);
    chk(halted, 0);
    mrk = 0;
  endtask
  task t_shift;
    sw.shift_step_hold_switch = 1;
    proc.shift_enter = 1;
    tick(1);
    proc = '0;
    tick(3);
    chk(halted, 1);
    kick_keys;
    proc.shift_step_pulse_a = 1;
    tick(1);
    proc = '0;
    tick(3);
    chk(halted, 1);
    kick_keys;
    sw = '0;
  endtask
  task t_split;
    mhk = 1;
    sw.split_sync_inhibit_switch = 1;
    proc.address_time_pulse = 1;
    tick(2);
    chk(split, 0);
    sw = '0;
    tick(1);
    proc.address_time_pulse = 0;
    proc.fetch_pause_req = 1;
    tick(1);
    proc = '0;
    chk(split, 1);
    chk(mro, 1);
    chk(mfc, 0);
    mhk = 0;
  endtask
  task t_mem;
    mhk = 1;
    proc.mem_call_done = 1;
    tick(1);
    proc = '0;
    tick(2);
    chk(mlamp, 1);
    chk(sflag[1], 1);
    chk(sflag[0], 1);
    mrk = 1;
    kick_keys;
    chk(halted, 0);
    mrk = 0;
    mhk = 0;
    tick(1);
  endtask
  task t_repeat;
    sw.repeat_skip_switch = 1;
    kick = 1;
    tick(1);
    kick = 0;
    tick(1);
    chk(rds, 1);
    tick(4);
    sw = '0;
    arp = 1;
    kick = 1;
    tick(1);
    kick = 0;
    tick(3);
    chk(rds, 1);
    tick(2);
    arp = 0;
  endtask
  task report_and_stop;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // The scenarios need well under 200 cycles; allow ten times that
  initial
  begin
    #40000;
    num_errors++;
    report_and_stop;
  end
  initial
  begin
    tick(8);
    srst = 0;
    t_readin;
    t_arith;
    t_shift;
    t_split;
    t_mem;
    t_repeat;
    report_and_stop;
  end
endmodule
